// file: hw/stack_header_dev.sv
// switch end: sends extraction headers, receives injection headers
// assumes the far end answers on the same clock; link inputs are not resynchronised
`timescale 1ns/10ps
`default_nettype none
module stack_header_dev (
   input  wire logic                          clk,
   input  wire logic                          reset_n,
   input  wire logic                          ce,
   stack_link_if.dev                          link,
   input  wire logic                          misc_service_index_select,
   input  wire logic                          insert_enable,
   input  wire logic                          ext_req_valid,
   output logic                               ext_req_ready,
   input  wire stack_header_pkg::hdr_fields_t ext_req_fields,
   output logic                               inj_done,
   output var stack_header_pkg::hdr_fields_t  inj_fields,
   output logic                               inj_marker_error,
   output logic                               inj_tag_error,
   output logic                               inj_kind_error,
   output logic                               inj_length_error
);

   stack_header_pkg::tx_state_t tx_state;
   logic [95:0]                 tx_shift;
   logic [3:0]                  tx_count;
   logic                        tx_take;
   logic                        tx_start;
   logic                        tx_byte;
   logic                        tx_end;

   logic [95:0]                 rx_shift;
   logic [3:0]                  rx_count;
   logic [95:0]                 rx_word;
   logic                        rx_byte;
   logic                        rx_end;

   // request is swallowed silently when insertion is off
   assign tx_take  = ext_req_valid && ext_req_ready;
   assign tx_start = tx_take && insert_enable;
   assign tx_byte  = link.ext_valid && link.ext_ready && ce;
   assign tx_end   = tx_byte && (tx_count == stack_header_pkg::LAST_BYTE);

   assign ext_req_ready = ce && (tx_state == stack_header_pkg::TX_IDLE);
   assign link.ext_valid = (tx_state == stack_header_pkg::TX_SEND);
   assign link.ext_data  = tx_shift[95:88];
   assign link.ext_last  = (tx_state == stack_header_pkg::TX_SEND) &&
                           (tx_count == stack_header_pkg::LAST_BYTE);

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         tx_state <= stack_header_pkg::TX_IDLE;
      end else if (ce) begin
         case (tx_state)
            stack_header_pkg::TX_IDLE: begin
               if (tx_start) begin
                  tx_state <= stack_header_pkg::TX_SEND;
               end
            end
            stack_header_pkg::TX_SEND: begin
               if (tx_end) begin
                  tx_state <= stack_header_pkg::TX_IDLE;
               end
            end
            default: begin
               tx_state <= stack_header_pkg::TX_IDLE;
            end
         endcase
      end
   end

   // tag type leads, then the header, top bit in the first header byte
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         tx_shift <= 96'h0;
      end else if (ce) begin
         if (tx_start) begin
            tx_shift <= {stack_header_pkg::TAG_TYPE_CODE,
                         stack_header_pkg::build_header(ext_req_fields,
                                                        misc_service_index_select)};
         end else if (tx_byte) begin
            tx_shift <= {tx_shift[87:0], 8'h00};
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         tx_count <= stack_header_pkg::FIRST_BYTE;
      end else if (ce) begin
         if (tx_start || tx_end) begin
            tx_count <= stack_header_pkg::FIRST_BYTE;
         end else if (tx_byte) begin
            tx_count <= tx_count + 4'h1;
         end
      end
   end

   // stalls the far end only while ce is low: one byte is taken every enabled cycle
   assign link.inj_ready = ce;
   assign rx_byte = link.inj_valid && link.inj_ready;
   assign rx_end  = rx_byte && (link.inj_last || (rx_count == stack_header_pkg::LAST_BYTE));
   assign rx_word = {rx_shift[87:0], link.inj_data};

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         rx_count <= stack_header_pkg::FIRST_BYTE;
      end else if (ce) begin
         if (rx_end) begin
            rx_count <= stack_header_pkg::FIRST_BYTE;
         end else if (rx_byte) begin
            rx_count <= rx_count + 4'h1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         rx_shift <= 96'h0;
      end else if (ce) begin
         if (rx_byte) begin
            rx_shift <= rx_word;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         inj_done <= 1'b0;
      end else if (ce) begin
         inj_done <= rx_end;
      end
   end

   // results hold until the next header completes
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         inj_fields <= '0;
      end else if (ce) begin
         if (rx_end) begin
            inj_fields <= stack_header_pkg::parse_header(rx_word[79:0],
                                                         misc_service_index_select);
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         inj_marker_error <= 1'b0;
      end else if (ce) begin
         if (rx_end) begin
            inj_marker_error <= !rx_word[stack_header_pkg::POS_MARKER];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         inj_tag_error <= 1'b0;
      end else if (ce) begin
         if (rx_end) begin
            inj_tag_error <= (rx_word[95:80] != stack_header_pkg::TAG_TYPE_CODE);
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         inj_kind_error <= 1'b0;
      end else if (ce) begin
         if (rx_end) begin
            inj_kind_error <= (rx_word[stack_header_pkg::POS_FWD +: 3] ==
                               stack_header_pkg::FWD_RESERVED);
         end
      end
   end

   // a short or long burst still ends the header so the next one starts clean
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         inj_length_error <= 1'b0;
      end else if (ce) begin
         if (rx_end) begin
            inj_length_error <= !(link.inj_last &&
                                  (rx_count == stack_header_pkg::LAST_BYTE));
         end
      end
   end

endmodule
`default_nettype wire

// file: shared/stack_header_pkg.sv
// constants, field layout and build/parse functions of the stacking header
// assumes both link ends run on one clock and share this package
package stack_header_pkg;

   // value is arbitrary
   localparam logic [15:0] TAG_TYPE_CODE  = 16'h9a3c;
   localparam int          HDR_BYTES      = 10;
   localparam int          TAG_BYTES      = 2;
   localparam int          FRAME_BITS     = 8 * (HDR_BYTES + TAG_BYTES);
   localparam logic [3:0]  LAST_BYTE      = 4'hb;
   localparam logic [3:0]  FIRST_BYTE     = 4'h0;
   localparam int          POS_MARKER     = 79;
   localparam int          POS_SVC_CLASS  = 76;
   localparam int          POS_SVC_INDEX  = 64;
   localparam int          POS_AGGR       = 64;
   localparam int          POS_DROP_PREC  = 60;
   localparam int          POS_SUPER      = 59;
   localparam int          POS_IPRIO      = 56;
   localparam int          POS_CONGEST    = 55;
   localparam int          POS_TTL        = 48;
   localparam int          POS_LEARN      = 47;
   localparam int          POS_FWD        = 44;
   localparam int          POS_DEST_TYPE  = 42;
   localparam int          POS_TTL_KEEP   = 41;
   localparam int          POS_DEST_UNIT  = 37;
   localparam int          POS_DEST       = 32;
   localparam int          PROC_PORT_BITS = 4;

   typedef enum logic [2:0] {
      FWD_LOCAL_LOOKUP = 3'h0,
      FWD_LOGICAL      = 3'h1,
      FWD_PHYSICAL     = 3'h2,
      FWD_MULTICAST    = 3'h3,
      FWD_MIRROR       = 3'h4,
      FWD_PROC_UNIT    = 3'h5,
      FWD_PROC_ALL     = 3'h6,
      FWD_RESERVED     = 3'h7
   } forward_kind_t;

   typedef enum logic [1:0] {
      TX_IDLE = 2'b01,
      TX_SEND = 2'b10
   } tx_state_t;

   typedef struct packed {
      logic [2:0]    service_class;
      logic [11:0]   ingress_service_index;
      logic [3:0]    aggregation_code;
      logic [1:0]    drop_precedence;
      logic          super_priority;
      logic [2:0]    internal_priority;
      logic          ingress_congestion_kind;
      logic [4:0]    time_to_live;
      logic          learn_control;
      forward_kind_t forward_kind;
      logic [10:0]   rewrite_command;
      logic          dest_port_type;
      logic [4:0]    dest_unit;
      logic [4:0]    dest_port_number;
      logic [9:0]    multicast_group_index;
      logic          ttl_keep;
   } hdr_fields_t;

   function automatic logic [79:0] build_header(hdr_fields_t f, logic sel);
      logic [79:0] h;
      h = '0;
      h[POS_MARKER] = 1'b1;
      if (sel) begin
         h[POS_SVC_CLASS +: $bits(f.service_class)] = f.service_class;
         h[POS_SVC_INDEX +: $bits(f.ingress_service_index)] = f.ingress_service_index;
      end else begin
         h[POS_AGGR +: $bits(f.aggregation_code)] = f.aggregation_code;
      end
      h[POS_DROP_PREC +: $bits(f.drop_precedence)] = f.drop_precedence;
      h[POS_SUPER] = f.super_priority;
      h[POS_IPRIO +: $bits(f.internal_priority)] = f.internal_priority;
      h[POS_CONGEST] = f.ingress_congestion_kind;
      h[POS_TTL +: $bits(f.time_to_live)] = f.time_to_live;
      h[POS_LEARN] = f.learn_control;
      h[POS_FWD +: $bits(f.forward_kind)] = f.forward_kind;
      case (f.forward_kind)
         FWD_LOCAL_LOOKUP, FWD_MIRROR: begin
            h[POS_DEST +: $bits(f.rewrite_command)] = f.rewrite_command;
         end
         FWD_LOGICAL: begin
            h[POS_DEST_TYPE] = f.dest_port_type;
            h[POS_DEST_UNIT +: $bits(f.dest_unit)] = f.dest_unit;
            h[POS_DEST +: $bits(f.dest_port_number)] = f.dest_port_number;
         end
         FWD_PHYSICAL: begin
            h[POS_DEST_UNIT +: $bits(f.dest_unit)] = f.dest_unit;
            h[POS_DEST +: $bits(f.dest_port_number)] = f.dest_port_number;
         end
         FWD_MULTICAST: begin
            h[POS_DEST +: $bits(f.multicast_group_index)] = f.multicast_group_index;
         end
         FWD_PROC_UNIT: begin
            h[POS_DEST_UNIT +: $bits(f.dest_unit)] = f.dest_unit;
            h[POS_DEST +: PROC_PORT_BITS] = f.dest_port_number[PROC_PORT_BITS-1:0];
         end
         FWD_PROC_ALL: begin
            h[POS_TTL_KEEP] = f.ttl_keep;
            h[POS_DEST +: PROC_PORT_BITS] = f.dest_port_number[PROC_PORT_BITS-1:0];
         end
         default: begin
            h[POS_DEST] = 1'b0;
         end
      endcase
      return h;
   endfunction

   function automatic hdr_fields_t parse_header(logic [79:0] h, logic sel);
      hdr_fields_t f;
      f = '0;
      if (sel) begin
         f.service_class = h[POS_SVC_CLASS +: $bits(f.service_class)];
         f.ingress_service_index = h[POS_SVC_INDEX +: $bits(f.ingress_service_index)];
      end else begin
         f.aggregation_code = h[POS_AGGR +: $bits(f.aggregation_code)];
      end
      f.drop_precedence = h[POS_DROP_PREC +: $bits(f.drop_precedence)];
      f.super_priority = h[POS_SUPER];
      f.internal_priority = h[POS_IPRIO +: $bits(f.internal_priority)];
      f.ingress_congestion_kind = h[POS_CONGEST];
      f.time_to_live = h[POS_TTL +: $bits(f.time_to_live)];
      f.learn_control = h[POS_LEARN];
      f.forward_kind = forward_kind_t'(h[POS_FWD +: $bits(f.forward_kind)]);
      case (f.forward_kind)
         FWD_LOCAL_LOOKUP, FWD_MIRROR: begin
            f.rewrite_command = h[POS_DEST +: $bits(f.rewrite_command)];
         end
         FWD_LOGICAL, FWD_PHYSICAL: begin
            f.dest_port_type = (f.forward_kind == FWD_LOGICAL) ? h[POS_DEST_TYPE] : 1'b0;
            f.dest_unit = h[POS_DEST_UNIT +: $bits(f.dest_unit)];
            f.dest_port_number = h[POS_DEST +: $bits(f.dest_port_number)];
         end
         FWD_MULTICAST: begin
            f.multicast_group_index = h[POS_DEST +: $bits(f.multicast_group_index)];
         end
         FWD_PROC_UNIT, FWD_PROC_ALL: begin
            if (f.forward_kind == FWD_PROC_UNIT) begin
               f.dest_unit = h[POS_DEST_UNIT +: $bits(f.dest_unit)];
            end else begin
               f.ttl_keep = h[POS_TTL_KEEP];
            end
            f.dest_port_number = {1'b0, h[POS_DEST +: PROC_PORT_BITS]};
         end
         default: begin
            f.ttl_keep = 1'b0;
         end
      endcase
      return f;
   endfunction

endpackage

// file: shared/stack_link_if.sv
// byte stream link between the switch end and the far end
// assumes one clock for both ends; ready may be combinational
`timescale 1ns/10ps
`default_nettype none
interface stack_link_if;
   logic       ext_valid;
   logic       ext_ready;
   logic [7:0] ext_data;
   logic       ext_last;
   logic       inj_valid;
   logic       inj_ready;
   logic [7:0] inj_data;
   logic       inj_last;

   modport dev (
      output ext_valid,
      input  ext_ready,
      output ext_data,
      output ext_last,
      input  inj_valid,
      output inj_ready,
      input  inj_data,
      input  inj_last
   );

   modport far (
      input  ext_valid,
      output ext_ready,
      input  ext_data,
      input  ext_last,
      output inj_valid,
      input  inj_ready,
      output inj_data,
      output inj_last
   );
endinterface
`default_nettype wire

// file: hw/stack_header_far.sv
// far end: sends injection headers, receives extraction headers
// assumes the switch end shares the clock
`timescale 1ns/10ps
`default_nettype none
module stack_header_far (
   input  wire logic                          clk,
   input  wire logic                          reset_n,
   input  wire logic                          ce,
   stack_link_if.far                          link,
   input  wire logic                          misc_service_index_select,
   input  wire logic                          inj_req_valid,
   output logic                               inj_req_ready,
   input  wire stack_header_pkg::hdr_fields_t inj_req_fields,
   output logic                               ext_done,
   output var stack_header_pkg::hdr_fields_t  ext_fields,
   output logic                               ext_marker_error,
   output logic                               ext_length_error
);

   stack_header_pkg::tx_state_t tx_state;
   logic [95:0]                 tx_shift;
   logic [3:0]                  tx_count;
   logic                        tx_start;
   logic                        tx_byte;
   logic                        tx_end;
   logic [3:0]                  rx_count;
   logic [95:0]                 rx_shift;
   logic [95:0]                 rx_word;
   logic                        rx_byte;
   logic                        rx_end;

   assign inj_req_ready  = ce && (tx_state == stack_header_pkg::TX_IDLE);
   assign tx_start       = inj_req_valid && inj_req_ready;
   assign tx_byte        = link.inj_valid && link.inj_ready && ce;
   assign tx_end         = tx_byte && (tx_count == stack_header_pkg::LAST_BYTE);
   assign link.inj_valid = (tx_state == stack_header_pkg::TX_SEND);
   assign link.inj_data  = tx_shift[95:88];
   assign link.inj_last  = link.inj_valid && (tx_count == stack_header_pkg::LAST_BYTE);

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         tx_state <= stack_header_pkg::TX_IDLE;
         tx_count <= stack_header_pkg::FIRST_BYTE;
         tx_shift <= 96'h0;
      end else if (ce) begin
         case (tx_state)
            stack_header_pkg::TX_IDLE: begin
               if (tx_start) begin
                  tx_state <= stack_header_pkg::TX_SEND;
                  tx_count <= stack_header_pkg::FIRST_BYTE;
                  tx_shift <= {stack_header_pkg::TAG_TYPE_CODE,
                               stack_header_pkg::build_header(inj_req_fields,
                                                              misc_service_index_select)};
               end
            end
            stack_header_pkg::TX_SEND: begin
               if (tx_end) begin
                  tx_state <= stack_header_pkg::TX_IDLE;
               end
               if (tx_byte) begin
                  tx_count <= tx_count + 4'h1;
                  tx_shift <= {tx_shift[87:0], 8'h00};
               end
            end
            default: begin
               tx_state <= stack_header_pkg::TX_IDLE;
            end
         endcase
      end
   end

   assign link.ext_ready = ce;
   assign rx_byte = link.ext_valid && link.ext_ready;
   assign rx_end  = rx_byte && (link.ext_last || (rx_count == stack_header_pkg::LAST_BYTE));
   assign rx_word = {rx_shift[87:0], link.ext_data};

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         rx_count <= stack_header_pkg::FIRST_BYTE;
         rx_shift <= 96'h0;
      end else if (ce) begin
         if (rx_byte) begin
            rx_shift <= rx_word;
            rx_count <= rx_end ? stack_header_pkg::FIRST_BYTE : rx_count + 4'h1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         ext_done         <= 1'b0;
         ext_fields       <= '0;
         ext_marker_error <= 1'b0;
         ext_length_error <= 1'b0;
      end else if (ce) begin
         ext_done <= rx_end;
         if (rx_end) begin
            ext_fields       <= stack_header_pkg::parse_header(rx_word[79:0],
                                                               misc_service_index_select);
            ext_marker_error <= !rx_word[stack_header_pkg::POS_MARKER];
            ext_length_error <= !(link.ext_last && (rx_count == stack_header_pkg::LAST_BYTE));
         end
      end
   end

endmodule
`default_nettype wire

// file: testbench/stack_link_checker.sv
// wire checker for the stacking header link between both ends
// assumes ready is the receiving end's run enable
`timescale 1ns/10ps
`default_nettype none
module stack_link_checker (
   input wire logic       clk,
   input wire logic       reset_n,
   input wire logic       ext_valid,
   input wire logic       ext_ready,
   input wire logic [7:0] ext_data,
   input wire logic       ext_last,
   input wire logic       inj_valid,
   input wire logic       inj_ready,
   input wire logic [7:0] inj_data,
   input wire logic       inj_last
);
   localparam logic [15:0] TAG = stack_header_pkg::TAG_TYPE_CODE;
   logic [3:0] ecnt;
   logic [3:0] icnt;
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   // byte position counters restart after every last byte
   always_ff @(posedge clk) begin
      if (!reset_n || (ext_valid && ext_ready && ext_last)) begin
         ecnt <= 4'h0;
      end else if (ext_valid && ext_ready) begin
         ecnt <= ecnt + 4'h1;
      end
   end
   always_ff @(posedge clk) begin
      if (!reset_n || (inj_valid && inj_ready && inj_last)) begin
         icnt <= 4'h0;
      end else if (inj_valid && inj_ready) begin
         icnt <= icnt + 4'h1;
      end
   end
   property p_ext_tag_hi;
      ext_valid && ecnt == 4'h0 |-> ext_data == TAG[15:8];
   endproperty
   a_ext_tag_hi: assert property (p_ext_tag_hi) else $error("first byte not tag high");
   property p_ext_tag_lo;
      ext_valid && ecnt == 4'h1 |-> ext_data == TAG[7:0];
   endproperty
   a_ext_tag_lo: assert property (p_ext_tag_lo) else $error("second byte not tag low");
   property p_ext_marker;
      ext_valid && ecnt == 4'h2 |-> ext_data[7];
   endproperty
   a_ext_marker: assert property (p_ext_marker) else $error("top header bit clear");
   property p_ext_rsv;
      ext_valid |-> !((ecnt == 4'h4 && ext_data[7:6] != 2'h0) ||
         (ecnt == 4'h5 && ext_data[6:5] != 2'h0) || (ecnt == 4'h6 && ext_data[3]));
   endproperty
   a_ext_rsv: assert property (p_ext_rsv) else $error("reserved header bit set");
   property p_ext_last;
      ext_valid |-> ext_last == (ecnt == 4'hb);
   endproperty
   a_ext_last: assert property (p_ext_last) else $error("last not on twelfth byte");
   property p_ext_hold;
      ext_valid && !ext_ready |=> ext_valid && $stable(ext_data) && $stable(ext_last);
   endproperty
   a_ext_hold: assert property (p_ext_hold) else $error("byte changed while stalled");
   property p_ext_gap;
      ext_valid && ext_ready && ext_last |=> !ext_valid;
   endproperty
   a_ext_gap: assert property (p_ext_gap) else $error("frame longer than twelve bytes");
   property p_inj_marker;
      inj_valid && inj_ready && icnt == 4'h1 |-> inj_data == TAG[7:0] ##1 inj_data[7];
   endproperty
   a_inj_marker: assert property (p_inj_marker) else $error("injected marker clear");
   property p_inj_last;
      inj_valid |-> inj_last == (icnt == 4'hb);
   endproperty
   a_inj_last: assert property (p_inj_last) else $error("injected last misplaced");
endmodule
`default_nettype wire

// file: testbench/tb_top.sv
// bench joining the switch end and the far end back to back
// assumes the handshake and field layout of the shared package
`timescale 1ns/10ps
`default_nettype none
`define CHECK(nm, e, g) check_val(nm, 96'(e), 96'(g))
module tb_top;
   logic                          clk;
   logic                          reset_n;
   logic                          ce_dev;
   logic                          ce_far;
   logic                          sel;
   logic                          insert_enable;
   logic                          ext_req_valid;
   logic                          ext_req_ready;
   stack_header_pkg::hdr_fields_t ext_req_fields;
   logic                          ext_done;
   stack_header_pkg::hdr_fields_t ext_fields;
   logic [1:0]                    ext_err;
   logic                          inj_req_valid;
   logic                          inj_req_ready;
   stack_header_pkg::hdr_fields_t inj_req_fields;
   logic                          inj_done;
   stack_header_pkg::hdr_fields_t inj_fields;
   logic [3:0]                    inj_err;
   logic [95:0]                   cap;
   int                            n_mismatch;
   int                            checks;
   stack_link_if link ();
   stack_header_dev stack_header_dev_i (.clk(clk), .reset_n(reset_n), .ce(ce_dev),
      .link(link.dev), .misc_service_index_select(sel), .insert_enable(insert_enable),
      .ext_req_valid(ext_req_valid), .ext_req_ready(ext_req_ready),
      .ext_req_fields(ext_req_fields), .inj_done(inj_done), .inj_fields(inj_fields),
      .inj_marker_error(inj_err[3]), .inj_tag_error(inj_err[2]),
      .inj_kind_error(inj_err[1]), .inj_length_error(inj_err[0]));
   stack_header_far stack_header_far_i (.clk(clk), .reset_n(reset_n), .ce(ce_far),
      .link(link.far), .misc_service_index_select(sel), .inj_req_valid(inj_req_valid),
      .inj_req_ready(inj_req_ready), .inj_req_fields(inj_req_fields), .ext_done(ext_done),
      .ext_fields(ext_fields), .ext_marker_error(ext_err[1]), .ext_length_error(ext_err[0]));
   stack_link_checker stack_link_checker_i (.clk(clk), .reset_n(reset_n),
      .ext_valid(link.ext_valid), .ext_ready(link.ext_ready), .ext_data(link.ext_data),
      .ext_last(link.ext_last), .inj_valid(link.inj_valid), .inj_ready(link.inj_ready),
      .inj_data(link.inj_data), .inj_last(link.inj_last));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // keeps the last twelve extraction bytes as seen on the wire
   always @(posedge clk) begin
      if (link.ext_valid && link.ext_ready) begin
         cap <= {cap[87:0], link.ext_data};
      end
   end
   task automatic check_val(input string nm, input logic [95:0] e, input logic [95:0] g);
      checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic tally_and_finish;
      if (n_mismatch == 0 && checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // only the fields that belong to kind k are filled, so a round trip returns them whole
   function automatic stack_header_pkg::hdr_fields_t mk(input logic [2:0] k, input logic s);
      mk = '{service_class: s ? 3'h5 : 3'h0, ingress_service_index: s ? 12'hfa5 : 12'h000,
         aggregation_code: s ? 4'h0 : 4'hc, drop_precedence: k[1:0], super_priority: k[0],
         internal_priority: k, ingress_congestion_kind: ~k[0], time_to_live: {2'h2, k},
         learn_control: k[1], forward_kind: stack_header_pkg::forward_kind_t'(k),
         rewrite_command: (k inside {3'h0, 3'h4}) ? 11'h5a5 ^ {8'h00, k} : 11'h000,
         dest_port_type: k == 3'h1, dest_unit: (k inside {1, 2, 5}) ? 5'h10 + 5'(k) : 5'h00,
         dest_port_number: (k inside {1, 2}) ? 5'h1d : (k inside {5, 6}) ? 5'h0e : 5'h00,
         multicast_group_index: k == 3'h3 ? 10'h2b6 : 10'h000, ttl_keep: k == 3'h6};
   endfunction
   function automatic logic [10:0] dst_of(input logic [2:0] k);
      case (k)
         3'h0, 3'h4: return 11'h5a5 ^ {8'h00, k};
         3'h1: return {1'b1, 5'h11, 5'h1d};
         3'h2: return {1'b0, 5'h12, 5'h1d};
         3'h3: return {1'b0, 10'h2b6};
         3'h5: return {1'b0, 5'h15, 1'b0, 4'he};
         3'h6: return {2'b01, 5'h00, 4'he};
         default: return 11'h000;
      endcase
   endfunction
   task automatic ext_xfer(input logic [2:0] k, input logic s, input logic stall);
      int n;
      @(posedge clk);
      sel <= s;
      @(posedge clk);
      ext_req_fields <= mk(k, s);
      ext_req_valid <= 1'b1;
      @(negedge clk);
      for (n = 0; n < 200 && ext_req_ready !== 1'b1; n++) @(negedge clk);
      @(posedge clk);
      ext_req_valid <= 1'b0;
      if (stall) begin
         repeat (3) @(posedge clk);
         ce_far <= 1'b0;
         repeat (4) @(posedge clk);
         ce_far <= 1'b1;
      end
      for (n = 0; n < 200 && ext_done !== 1'b1; n++) @(negedge clk);
      `CHECK("ext_fields", mk(k, s), ext_fields);
      `CHECK("ext_errors", 3'h4, {ext_done, ext_err});
      `CHECK("ext_tag", stack_header_pkg::TAG_TYPE_CODE, cap[95:80]);
      `CHECK("ext_qos", {k[1:0], k[0], k, ~k[0], 2'h2, k, k[1], k}, {cap[61:55], cap[52:44]});
      `CHECK("ext_dest", dst_of(k), cap[42:32]);
      `CHECK("ext_misc", s ? {3'h5, 12'hfa5} : 15'h000c, cap[78:64]);
   endtask
   task automatic inj_xfer(input logic [2:0] k, input logic s, input logic stall);
      int n;
      @(posedge clk);
      sel <= s;
      @(posedge clk);
      inj_req_fields <= mk(k, s);
      inj_req_valid <= 1'b1;
      @(negedge clk);
      for (n = 0; n < 200 && inj_req_ready !== 1'b1; n++) @(negedge clk);
      @(posedge clk);
      inj_req_valid <= 1'b0;
      if (stall) begin
         repeat (5) @(posedge clk);
         ce_dev <= 1'b0;
         repeat (3) @(posedge clk);
         ce_dev <= 1'b1;
      end
      for (n = 0; n < 200 && inj_done !== 1'b1; n++) @(negedge clk);
      `CHECK("inj_fields", mk(k, s), inj_fields);
      `CHECK("inj_errors", k == 3'h7 ? 5'h12 : 5'h10, {inj_done, inj_err});
      `CHECK("inj_req_ready", 1'b1, inj_req_ready);
   endtask
   task automatic t_ext_all;
      for (int k = 0; k < 7; k++) begin
         ext_xfer(3'(k), k[0], k == 3);
      end
   endtask
   task automatic t_inj_all;
      for (int k = 0; k < 8; k++) begin
         inj_xfer(3'(k), ~k[0], k == 2);
      end
   endtask
   // a consumed request with insertion off must leave the wire quiet
   task automatic t_no_insert;
      int n;
      int seen;
      @(posedge clk);
      insert_enable <= 1'b0;
      ext_req_fields <= mk(3'h3, 1'b0);
      ext_req_valid <= 1'b1;
      @(negedge clk);
      for (n = 0; n < 200 && ext_req_ready !== 1'b1; n++) @(negedge clk);
      @(posedge clk);
      ext_req_valid <= 1'b0;
      seen = 0;
      repeat (16) begin
         @(negedge clk);
         if (link.ext_valid !== 1'b0 || ext_done !== 1'b0) seen++;
      end
      `CHECK("quiet_without_insert", 0, seen);
      `CHECK("ready_after_consume", 1'b1, ext_req_ready);
      @(posedge clk);
      insert_enable <= 1'b1;
   endtask
   initial begin
      reset_n = 1'b0;
      ce_dev = 1'b1;
      ce_far = 1'b1;
      sel = 1'b0;
      insert_enable = 1'b1;
      ext_req_valid = 1'b0;
      ext_req_fields = '0;
      inj_req_valid = 1'b0;
      inj_req_fields = '0;
      n_mismatch = 0;
      checks = 0;
      repeat (4) @(posedge clk);
      reset_n <= 1'b1;
      t_ext_all;
      t_inj_all;
      t_no_insert;
      ext_xfer(3'h1, 1'b1, 1'b0);
      tally_and_finish;
   end
   // about 20 cycles per transfer, limit kept well above the whole run
   initial begin
      #(25 * 4000);
      n_mismatch++;
      tally_and_finish;
   end
endmodule
`default_nettype wire
